// *** level_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module level_filter
#(
	parameter int unsigned COUNT = rst_seq_pkg::HYST_CYCLES
)(
	input  wire logic clk_sys_i,
	input  wire logic rst_b_i,
	input  wire logic en_i,
	input  wire logic raw_i,
	output logic      level_o
);
	import rst_seq_pkg::*;

	logic       s1_q;
	logic       s2_q;
	logic       lvl_q;
	logic       lvl_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;

	if (COUNT < 1 || COUNT > 15)
	begin : g_count_bad
		$error("level_filter COUNT out of range");
	end

	always_comb
	begin
		lvl_d = lvl_q;
		cnt_d = HYST_RST;
		if (s2_q != lvl_q)
		begin
			if (cnt_q == 4'(COUNT - 1))
				lvl_d = s2_q;
			else
				cnt_d = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			lvl_q <= 1'b1;
			cnt_q <= HYST_RST;
		end
		else if (en_i)
		begin
			s1_q  <= raw_i;
			s2_q  <= s1_q;
			lvl_q <= lvl_d;
			cnt_q <= cnt_d;
		end
	end

	assign level_o = lvl_q;
endmodule
`default_nettype wire

// *** reset_brownout_sequencer.sv ***
// What this block does
// - chip reset merges pin, watchdog, power-on and brownout low stage.
// - any reset source, once supply usable, restarts the wake-up timer.
// - hold reset until pin released, oscillator runs, count done, flash ready.
// - on release the processor starts at address zero via boot vectors.
// - peripheral and core registers sit at reset values before release.
// - supply below 2.95 V raises the brownout interrupt request.
// - interrupt gated by enable; level always readable as status.
// - supply below 2.65 V asserts chip reset, blocking flash writes.
// - brownout holds reset down to 1 V, then power-on detector holds.
// - both brownout thresholds are filtered with hysteresis.
// - map select chooses boot ROM or SRAM vectors at address zero.
// - after any chip reset the internal RC oscillator clocks the chip.
// - on chip reset the PLL is disabled and bypassed.
`timescale 1ns/1ps
`default_nettype none
module reset_brownout_sequencer
#(
	parameter int unsigned WAKE_COUNT = rst_seq_pkg::WAKE_CYCLES
)(
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	input  wire logic       ce_i,
	input  wire logic       ext_rst_b_i,
	input  wire logic       wdt_rst_i,
	input  wire logic       por_b_i,
	input  wire logic       vdd_ok_irq_i,
	input  wire logic       vdd_ok_rst_i,
	input  wire logic       osc_running_i,
	input  wire logic       flash_init_done_i,
	input  wire logic       brownout_irq_en_i,
	input  wire logic       map_sram_i,
	input  wire logic       map_wr_i,
	input  wire logic [1:0] clk_src_i,
	input  wire logic       clk_src_wr_i,
	input  wire logic       pll_en_i,
	input  wire logic       pll_connect_i,
	output logic            chip_rst_b_o,
	output logic            periph_rst_b_o,
	output logic            flash_init_start_o,
	output logic            flash_wr_block_o,
	output logic            cpu_start_o,
	output logic [31:0]     fetch_addr_o,
	output logic            vector_map_o,
	output logic            brownout_irq_o,
	output logic            brownout_status_o,
	output logic [1:0]      clk_src_o,
	output logic            pll_en_o,
	output logic            pll_connect_o
);
	import rst_seq_pkg::*;

	if (WAKE_COUNT < 1 || WAKE_COUNT >= (1 << WAKE_CNT_W))
	begin : g_wake_bad
		$error("WAKE_COUNT out of range");
	end

	logic ext_b_f;
	logic irq_ok_f;
	logic rst_ok_f;
	logic wdt_s1_q;
	logic wdt_s2_q;
	logic src_rst;

	level_filter #(.COUNT(PIN_FILT_CYCLES)) u_pin (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.en_i      (ce_i),
		.raw_i     (ext_rst_b_i),
		.level_o   (ext_b_f)
	);
	level_filter #(.COUNT(HYST_CYCLES)) u_irq_stage (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.en_i      (ce_i),
		.raw_i     (vdd_ok_irq_i),
		.level_o   (irq_ok_f)
	);
	level_filter #(.COUNT(HYST_CYCLES)) u_rst_stage (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.en_i      (ce_i),
		.raw_i     (vdd_ok_rst_i),
		.level_o   (rst_ok_f)
	);

	// por_b_i is the power-on detector, which owns reset below 1 V
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wdt_s1_q <= 1'b0;
			wdt_s2_q <= 1'b0;
		end
		else if (ce_i)
		begin
			wdt_s1_q <= wdt_rst_i;
			wdt_s2_q <= wdt_s1_q;
		end
	end

	assign src_rst = !ext_b_f || wdt_s2_q || !por_b_i || !rst_ok_f;

	seq_state_t               st_q;
	seq_state_t               st_d;
	logic [WAKE_CNT_W-1:0]    cnt_q;
	logic [WAKE_CNT_W-1:0]    cnt_d;
	logic                     chip_b_d;
	logic                     start_d;

	always_comb
	begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		chip_b_d = 1'b0;
		start_d  = 1'b0;
		case (st_q)
			SEQ_HOLD:
			begin
				cnt_d = '0;
				if (osc_running_i && ext_b_f)
					st_d = SEQ_WAKE;
			end
			SEQ_WAKE:
			begin
				if (!osc_running_i)
					st_d = SEQ_HOLD;
				else if (cnt_q == WAKE_CNT_W'(WAKE_COUNT - 1))
					st_d = SEQ_FLASH;
				else
					cnt_d = cnt_q + 1'b1;
			end
			SEQ_FLASH:
			begin
				if (flash_init_done_i)
				begin
					st_d     = SEQ_RUN;
					chip_b_d = 1'b1;
					start_d  = 1'b1;
				end
			end
			SEQ_RUN:
				chip_b_d = 1'b1;
			default:
				st_d = SEQ_HOLD;
		endcase
		if (src_rst)
		begin
			st_d     = SEQ_HOLD;
			cnt_d    = '0;
			chip_b_d = 1'b0;
			start_d  = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_q           <= SEQ_HOLD;
			cnt_q          <= '0;
			chip_rst_b_o   <= 1'b0;
			periph_rst_b_o <= 1'b0;
			cpu_start_o    <= 1'b0;
		end
		else if (ce_i)
		begin
			st_q           <= st_d;
			cnt_q          <= cnt_d;
			chip_rst_b_o   <= chip_b_d;
			periph_rst_b_o <= chip_b_d;
			cpu_start_o    <= start_d;
		end
	end

	logic [1:0] src_d;
	logic       map_d;
	logic       pll_en_d;
	logic       pll_con_d;
	logic       held;

	assign held = !chip_rst_b_o;

	always_comb
	begin
		src_d     = clk_src_o;
		map_d     = vector_map_o;
		pll_en_d  = pll_en_i;
		pll_con_d = pll_connect_i && pll_en_i;
		if (clk_src_wr_i)
			src_d = clk_src_i;
		if (map_wr_i)
			map_d = map_sram_i ? MAP_SRAM : MAP_BOOT_ROM;
		if (held || !chip_b_d)
		begin
			src_d     = CLKSRC_RC;
			map_d     = MAP_BOOT_ROM;
			pll_en_d  = 1'b0;
			pll_con_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			clk_src_o          <= CLKSRC_RC;
			vector_map_o       <= MAP_BOOT_ROM;
			pll_en_o           <= 1'b0;
			pll_connect_o      <= 1'b0;
			fetch_addr_o       <= START_ADDR;
			flash_init_start_o <= 1'b0;
			flash_wr_block_o   <= 1'b1;
			brownout_irq_o     <= 1'b0;
			brownout_status_o  <= 1'b0;
		end
		else if (ce_i)
		begin
			clk_src_o          <= src_d;
			vector_map_o       <= map_d;
			pll_en_o           <= pll_en_d;
			pll_connect_o      <= pll_con_d;
			fetch_addr_o       <= START_ADDR;
			flash_init_start_o <= (st_d == SEQ_FLASH);
			flash_wr_block_o   <= !chip_b_d;
			brownout_status_o  <= !irq_ok_f;
			brownout_irq_o     <= !irq_ok_f && brownout_irq_en_i;
		end
	end

	chk_reset_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		ce_i && src_rst |=> !chip_rst_b_o)
		else $error("reset source did not hold chip reset");
	chk_flash_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		ce_i && $rose(chip_rst_b_o) |-> $past(flash_init_done_i))
		else $error("release without flash ready");
	chk_wake_count: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		ce_i && st_q == SEQ_FLASH && $past(st_q) == SEQ_WAKE |-> $past(cnt_q) == WAKE_CNT_W'(WAKE_COUNT - 1))
		else $error("wake count wrong");
	chk_start_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		cpu_start_o |-> fetch_addr_o == START_ADDR && chip_rst_b_o && vector_map_o == MAP_BOOT_ROM)
		else $error("bad start");
	chk_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		$past(ce_i) |-> brownout_irq_o == (brownout_status_o && $past(brownout_irq_en_i)))
		else $error("irq not status gated by enable");
	chk_brownout_rst: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!rst_ok_f && ce_i |=> flash_wr_block_o && !chip_rst_b_o)
		else $error("brownout reset missing");
	chk_rc_on_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!chip_rst_b_o |-> clk_src_o == CLKSRC_RC)
		else $error("clock source not rc in reset");
	chk_pll_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!chip_rst_b_o |-> !pll_en_o && !pll_connect_o)
		else $error("pll active in reset");
	chk_periph_rst: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		periph_rst_b_o == chip_rst_b_o)
		else $error("peripheral reset skew");
	cov_release: cover property (@(posedge clk_sys_i) $rose(chip_rst_b_o));
	cov_brownout_irq: cover property (@(posedge clk_sys_i) $rose(brownout_irq_o));
	cov_wdt: cover property (@(posedge clk_sys_i) chip_rst_b_o ##1 wdt_s2_q);
	cov_sram_map: cover property (@(posedge clk_sys_i) vector_map_o == MAP_SRAM);
endmodule
`default_nettype wire

// *** rst_seq_pkg.sv ***
package rst_seq_pkg;
	// wake-up count of sequencer clocks once reset sources and oscillator hold clear, before flash init
	localparam int unsigned WAKE_CYCLES        = 32'd4096;
	localparam int unsigned WAKE_CNT_W         = 13;
	// glitch filter length on the external reset pin
	localparam int unsigned PIN_FILT_CYCLES    = 2;
	// brownout threshold figures in millivolts
	localparam int unsigned BROWNOUT_IRQ_MV    = 2950;
	localparam int unsigned BROWNOUT_RST_MV    = 2650;
	localparam int unsigned POR_TAKEOVER_MV    = 1000;
	// qualification count used as digital hysteresis on comparator edges
	localparam int unsigned HYST_CYCLES        = 8;
	localparam logic [3:0]  HYST_RST           = 4'h0;
	// vector map select encoding
	localparam logic        MAP_BOOT_ROM       = 1'b0;
	localparam logic        MAP_SRAM           = 1'b1;
	localparam logic [31:0] START_ADDR         = 32'h0000_0000;
	// clock source select encoding
	localparam logic [1:0]  CLKSRC_RC          = 2'h0;
	localparam logic [1:0]  CLKSRC_MAIN        = 2'h1;
	localparam logic [1:0]  CLKSRC_RTC         = 2'h2;
	typedef enum logic [1:0] {
		SEQ_HOLD,
		SEQ_WAKE,
		SEQ_FLASH,
		SEQ_RUN
	} seq_state_t;
endpackage

// *** supply_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module supply_partner
	import rst_seq_pkg::*;
(
	input  wire logic [11:0] mv_i,
	input  wire logic        pin_low_i,
	input  wire logic        wdt_i,
	output logic             ext_rst_b_o,
	output logic             wdt_rst_o,
	output logic             por_b_o,
	output logic             vdd_ok_irq_o,
	output logic             vdd_ok_rst_o
);
	// pin and watchdog request as plain levels
	assign ext_rst_b_o  = !pin_low_i;
	assign wdt_rst_o    = wdt_i;
	// comparators against the supply in millivolts
	assign por_b_o      = (mv_i >= 12'(POR_TAKEOVER_MV));
	assign vdd_ok_irq_o = (mv_i >= 12'(BROWNOUT_IRQ_MV));
	assign vdd_ok_rst_o = (mv_i >= 12'(BROWNOUT_RST_MV));
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rst_seq_pkg::*;
	logic        clk_sys_i = 0, rst_b_i = 0, osc = 1, fdone = 0, irq_en = 0, ce = 1;
	logic        map_sram = 0, map_wr = 0, ck_wr = 0, pll_en = 0, pll_con = 0;
	logic        pin_low = 0, wdt = 0;
	logic [1:0]  ck_src = 2'h0;
	logic [11:0] mv = 12'hce4;
	logic        ext_b, wdt_r, por_b, ok_irq, ok_rst;
	logic        chip_b, per_b, fstart, fblock, cpu_st, vmap, irq, stat, pll_q, con_q;
	logic [31:0] faddr;
	logic [1:0]  csrc;
	int          mismatches = 0;
	int          checked = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	supply_partner sp (.mv_i(mv), .pin_low_i(pin_low), .wdt_i(wdt), .ext_rst_b_o(ext_b),
		.wdt_rst_o(wdt_r), .por_b_o(por_b), .vdd_ok_irq_o(ok_irq), .vdd_ok_rst_o(ok_rst));
	reset_brownout_sequencer #(.WAKE_COUNT(8)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.ce_i(ce), .ext_rst_b_i(ext_b), .wdt_rst_i(wdt_r), .por_b_i(por_b),
		.vdd_ok_irq_i(ok_irq), .vdd_ok_rst_i(ok_rst), .osc_running_i(osc),
		.flash_init_done_i(fdone), .brownout_irq_en_i(irq_en), .map_sram_i(map_sram),
		.map_wr_i(map_wr), .clk_src_i(ck_src), .clk_src_wr_i(ck_wr), .pll_en_i(pll_en),
		.pll_connect_i(pll_con), .chip_rst_b_o(chip_b), .periph_rst_b_o(per_b),
		.flash_init_start_o(fstart), .flash_wr_block_o(fblock), .cpu_start_o(cpu_st),
		.fetch_addr_o(faddr), .vector_map_o(vmap), .brownout_irq_o(irq),
		.brownout_status_o(stat),
		.clk_src_o(csrc), .pll_en_o(pll_q), .pll_connect_o(con_q));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic wait_rst(input logic v, input int n);
		int i;
		i = 0;
		while (chip_b !== v && i < n)
		begin
			tick(1);
			i++;
		end
		chk(chip_b, v);
	endtask
	task automatic power_up();
		tick(40);
		chk(chip_b, 1'b0);
		chk(fstart, 1'b1);
		chk(csrc, CLKSRC_RC);
		chk(pll_q, 1'b0);
		chk(vmap, MAP_BOOT_ROM);
		chk(fblock, 1'b1);
		fdone = 1;
		wait_rst(1'b1, 5);
		chk(cpu_st, 1'b1);
		chk(faddr, START_ADDR);
		chk(per_b, 1'b1);
		chk(fblock, 1'b0);
		chk(fstart, 1'b0);
		tick(1);
		chk(cpu_st, 1'b0);
	endtask
	task automatic ctrl_and_wdt();
		map_sram = 1;
		map_wr = 1;
		ck_src = CLKSRC_MAIN;
		ck_wr = 1;
		pll_en = 1;
		pll_con = 1;
		tick(1);
		map_wr = 0;
		ck_wr = 0;
		tick(2);
		chk(vmap, MAP_SRAM);
		chk(csrc, CLKSRC_MAIN);
		chk(con_q, 1'b1);
		chk(pll_q, 1'b1);
		wdt = 1;
		wait_rst(1'b0, 6);
		pll_en = 0;
		pll_con = 0;
		map_wr = 1;
		ck_wr = 1;
		tick(1);
		map_wr = 0;
		ck_wr = 0;
		chk(csrc, CLKSRC_RC);
		chk(pll_q, 1'b0);
		chk(vmap, MAP_BOOT_ROM);
		wdt = 0;
		tick(8);
		chk(chip_b, 1'b0);
		wait_rst(1'b1, 40);
	endtask
	task automatic ce_freeze();
		ce = 0;
		wdt = 1;
		map_sram = 1;
		map_wr = 1;
		tick(5);
		chk(chip_b, 1'b1);
		chk(vmap, MAP_BOOT_ROM);
		wdt = 0;
		map_wr = 0;
		ce = 1;
		tick(5);
		chk(chip_b, 1'b1);
		chk(vmap, MAP_BOOT_ROM);
	endtask
	task automatic pin_and_osc();
		pin_low = 1;
		wait_rst(1'b0, 8);
		osc = 0;
		tick(1);
		pin_low = 0;
		tick(30);
		chk(chip_b, 1'b0);
		osc = 1;
		tick(4);
		osc = 0;
		tick(1);
		osc = 1;
		tick(6);
		chk(chip_b, 1'b0);
		wait_rst(1'b1, 40);
	endtask
	task automatic brownout();
		mv = 12'haf0;
		tick(20);
		chk(stat, 1'b1);
		chk(irq, 1'b0);
		chk(chip_b, 1'b1);
		irq_en = 1;
		tick(2);
		chk(irq, 1'b1);
		mv = 12'hce4;
		tick(20);
		mv = 12'haf0;
		tick(3);
		mv = 12'hce4;
		repeat (20)
		begin
			tick(1);
			chk(stat, 1'b0);
		end
		mv = 12'ha28;
		wait_rst(1'b0, 20);
		chk(fblock, 1'b1);
		mv = 12'h1f4;
		tick(20);
		chk(chip_b, 1'b0);
		mv = 12'hce4;
		wait_rst(1'b1, 60);
		chk(stat, 1'b0);
		chk(irq, 1'b0);
	endtask
	task automatic end_sim();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		tick(6);
		rst_b_i = 1;
		power_up();
		ctrl_and_wdt();
		ce_freeze();
		pin_and_osc();
		brownout();
		end_sim();
	end
	initial
	begin
		#100000;
		mismatches++;
		end_sim();
	end
endmodule
`default_nettype wire
